// File: dv/flash_host_model.sv
// Purpose: Host controller model that frames commands on the serial pins.
// Assumes: Single-wire or four-wire framing, bits sent MSB first from the top of the data word.
// Notes:   Phases last three reference cycles, slow enough for the guard to sample.
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  input  wire logic        ref_clk_i,
  input  wire logic        go_i,
  input  wire logic        quad_i,
  input  wire logic [47:0] data_i,
  input  wire logic [5:0]  nbits_i,
  output logic             sclk_o,
  output logic             sel_b_o,
  output logic [3:0]       io_o,
  output logic             done_o
);
  initial begin
    sclk_o  = 1'b0;
    sel_b_o = 1'b1;
    io_o    = 4'h0;
    done_o  = 1'b0;
    forever begin
      @(posedge ref_clk_i);
      if (go_i === 1'b1) begin
        sel_b_o <= 1'b0;
        for (int i = 0; i < int'(nbits_i); i += (quad_i ? 4 : 1)) begin
          io_o <= quad_i ? data_i[47 - i -: 4] : {3'h0, data_i[47 - i]};
          repeat (3) @(posedge ref_clk_i);
          sclk_o <= 1'b1;
          repeat (3) @(posedge ref_clk_i);
          sclk_o <= 1'b0;
        end
        repeat (3) @(posedge ref_clk_i);
        sel_b_o <= 1'b1;
        // A released line must not keep its last value.
        io_o    <= ~io_o;
        repeat (6) @(posedge ref_clk_i);
        done_o <= 1'b1;
        @(posedge ref_clk_i);
        done_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Purpose: Self-checking bench for the serial flash command guard.
// Assumes: Short operation counts; sector erase is long enough to be suspended.
// Notes:   Frame outcomes are queued by the driver and matched by the pulse monitor.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flash_guard_pkg::*;
  logic        ref_clk_i = 1'b0, rst_b_i = 1'b0, wp_b = 1'b1, go = 1'b0, quad = 1'b0;
  logic [47:0] data = 48'h0;
  logic [5:0]  nbits = 6'h0;
  logic [3:0]  io, dummy;
  logic [4:0]  bp;
  logic [1:0]  srp;
  logic [23:0] op_addr, a;
  op_kind_t    kind;
  wire logic   sclk, sel_b, done, busy, latch, susp, dpd, quad_mode, rej, start, fin;
  logic [5:0]  expq[$];
  logic [11:0] rd[4] = '{12'h0B8, 12'hBB4, 12'hEB6, 12'hED8};
  int          num_errors = 0, comparisons = 0, cycles = 0, seed = 32'h01b5ca20;
  always #20 ref_clk_i = ~ref_clk_i;
  flash_host_model host (.ref_clk_i(ref_clk_i), .go_i(go), .quad_i(quad), .data_i(data), .nbits_i(nbits), .sclk_o(sclk),
    .sel_b_o(sel_b), .io_o(io), .done_o(done));
  flash_guard #(.PAGE_PROG_CYC(20), .SECTOR_ERASE_CYC(2000), .STATUS_WRITE_CYC(20)) uut (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .sclk_i(sclk), .sel_b_i(sel_b), .io_i(io), .write_protect_b_i(wp_b), .busy_o(busy),
    .write_enable_latch_o(latch), .block_protect_bits_o(bp), .status_protect_bits_o(srp), .suspended_o(susp),
    .deep_power_down_o(dpd), .quad_command_mode_o(quad_mode), .cmd_reject_o(rej), .op_start_o(start),
    .op_kind_o(kind), .op_addr_o(op_addr), .op_done_o(fin), .read_dummy_o(dummy));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("Errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic frame(input logic [47:0] d, input int n, input logic [5:0] e, input logic q);
    if (q) expq.push_back(e);
    @(posedge ref_clk_i);
    data  <= d;
    nbits <= 6'(n);
    go    <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    // No local limit: a frame that never ends runs into the cycle ceiling.
    while (done !== 1'b1) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic write_enable_command();
    frame({CMD_WRITE_ENABLE, 40'h0}, 8, 6'h00, 1'b0);
  endtask
  task automatic idle();
    for (int k = 0; k < 100 && fin !== 1'b1; k++) @(posedge ref_clk_i);
    check({fin, busy}, 2'b10);
  endtask
  // A pulse with nothing queued for it is itself a mismatch.
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      num_errors++;
      test_done();
    end else if (start === 1'b1 || rej === 1'b1) begin
      if (expq.size() == 0) check(24'hFFFFFF, 24'h0);
      else check({start, rej, start ? kind : 4'h0}, expq.pop_front());
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    check({busy, latch, bp, srp, susp, dpd, quad_mode}, 24'h0);
    a = 24'($random(seed)) & 24'h7FFFFF;
    frame({CMD_PAGE_PROG, a, 16'h5A00}, 40, 6'h10, 1'b1);
    frame({CMD_WRITE_ENABLE, 40'h0}, 7, 6'h10, 1'b1);
    check(24'(latch), 24'h0);
    write_enable_command();
    check(24'(latch), 24'h1);
    frame({CMD_PAGE_PROG, a, 16'h5A00}, 40, {2'b10, OP_PAGE_PROG}, 1'b1);
    check({busy, op_addr}, {1'b1, a});
    idle();
    check(24'(latch), 24'h0);
    write_enable_command();
    frame({CMD_SECTOR_ERASE, a, 16'h0}, 32, {2'b10, OP_SECTOR_ERASE}, 1'b1);
    check({susp, op_addr}, {1'b0, a & ~SECTOR_MASK});
    frame({CMD_SUSPEND, 40'h0}, 8, 6'h00, 1'b0);
    repeat (750) @(posedge ref_clk_i);
    check({susp, busy}, 2'b10);
    // No second suspend follows the resume, so the resume spacing always holds.
    frame({CMD_RESUME, 40'h0}, 8, 6'h00, 1'b0);
    check({susp, busy}, 2'b01);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    check({susp, busy, latch}, 3'b000);
    write_enable_command();
    frame({CMD_STATUS_WRITE, 8'h1C, 32'h0}, 16, {2'b10, OP_STATUS_WRITE}, 1'b1);
    idle();
    check(24'(bp), 24'h07);
    write_enable_command();
    frame({CMD_SECTOR_ERASE, a, 16'h0}, 32, 6'h10, 1'b1);
    @(posedge ref_clk_i);
    wp_b <= 1'b0;
    write_enable_command();
    frame({CMD_STATUS_WRITE, 8'h00, 32'h0}, 16, {2'b10, OP_STATUS_WRITE}, 1'b1);
    idle();
    check(24'(bp), 24'h07);
    foreach (rd[i]) begin
      frame({rd[i][11:4], a, 16'h0}, 32, 6'h00, 1'b0);
      check(24'(dummy), 24'(rd[i][3:0]));
    end
    frame({CMD_QUAD_ON, 40'h0}, 8, 6'h00, 1'b0);
    check(24'(quad_mode), 24'h1);
    quad <= 1'b1;
    frame({CMD_FAST_READ, 40'h0}, 8, 6'h00, 1'b0);
    check(24'(dummy), 24'(DUMMY_10));
    frame({CMD_QUAD_OFF, 40'h0}, 8, 6'h00, 1'b0);
    quad <= 1'b0;
    check(24'(quad_mode), 24'h0);
    frame({CMD_SET_READ_PAR, 8'h10, 32'h0}, 16, 6'h00, 1'b0);
    frame({CMD_FAST_READ, 40'h0}, 8, 6'h00, 1'b0);
    check(24'(dummy), 24'(DUMMY_6));
    frame({CMD_DEEP_PD, 40'h0}, 8, 6'h00, 1'b0);
    check(24'(dpd), 24'h1);
    write_enable_command();
    check(24'(latch), 24'h0);
    frame({CMD_RELEASE_PD, 40'h0}, 8, 6'h00, 1'b0);
    check(24'(dpd), 24'h0);
    test_done();
  end
endmodule
`default_nettype wire

// File: hw/flash_guard.sv
// Purpose: Command framing, write protection and operation timing of a serial flash.
// Assumes: Serial pins are asynchronous to ref_clk_i and toggle well below its rate.
// Notes:   The array itself lives outside; this block starts and times its operations.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Suspend entry completes within 30 us.
// - Page program finishes within 2.4 ms.
// - Sector, block and chip erase bounded.
// - Security register program and erase bounded.
// - Single-wire reads use configured dummy counts.
// - Quad command mode reads default ten dummies.
// - Status reads zero after reset.
// - Sequencer starts in standby without commands.
// - Frames not ending on bytes are rejected, except in deep power-down.
// - Modifying commands need the write-enable latch.
// - Protected region refuses program and erase.
// - Write-protect low freezes protection bits.
// - Deep power-down ignores all but release.
module flash_guard
  import flash_guard_pkg::*;
#(
  parameter int unsigned PAGE_PROG_CYC    = PAGE_PROG_CYCLES,
  parameter int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_CYCLES,
  parameter int unsigned BLK32_ERASE_CYC  = BLK32_ERASE_CYCLES,
  parameter int unsigned BLK64_ERASE_CYC  = BLK64_ERASE_CYCLES,
  parameter int unsigned CHIP_ERASE_CYC   = CHIP_ERASE_CYCLES,
  parameter int unsigned SEC_PROG_CYC     = SEC_PROG_CYCLES,
  parameter int unsigned SEC_ERASE_CYC    = SEC_ERASE_CYCLES,
  parameter int unsigned STATUS_WRITE_CYC = STATUS_WRITE_CYCLES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       sclk_i,
  input  wire logic       sel_b_i,
  input  wire logic [3:0] io_i,
  input  wire logic       write_protect_b_i,
  output logic            busy_o,
  output logic            write_enable_latch_o,
  output logic [4:0]      block_protect_bits_o,
  output logic [1:0]      status_protect_bits_o,
  output logic            suspended_o,
  output logic            deep_power_down_o,
  output logic            quad_command_mode_o,
  output logic            cmd_reject_o,
  output logic            op_start_o,
  output var op_kind_t    op_kind_o,
  output logic [23:0]     op_addr_o,
  output logic            op_done_o,
  output logic [3:0]      read_dummy_o
);

  logic       sclk_s1, sclk_s2, sclk_d, sel_s1, sel_s2, sel_d, wp_s1, wp_s2;
  logic [3:0] io_s1, io_s2;
  logic [2:0] bit_cnt_reg;
  logic [3:0] byte_cnt_reg;
  logic [7:0] shift_reg, opc_reg;
  logic [23:0] addr_reg;
  seq_state_t state_reg, state_next;
  logic [30:0] remain_reg, elapsed_reg;
  logic [9:0] susp_cnt_reg;
  logic       rp_valid_reg;
  logic [1:0] rp_code_reg;
  logic [1:0] srp_next;
  logic [4:0] bp_next;

  // Every pin passes two flops; the edge detectors compare the second stage with a third, delayed flop.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      {sclk_s1, sclk_s2, sclk_d} <= 3'h0;
      {sel_s1, sel_s2, sel_d}    <= 3'h7;
      {wp_s1, wp_s2}             <= 2'h3;
      io_s1                      <= 4'h0;
      io_s2                      <= 4'h0;
    end else begin
      {sclk_s1, sclk_s2, sclk_d} <= {sclk_i, sclk_s1, sclk_s2};
      {sel_s1, sel_s2, sel_d}    <= {sel_b_i, sel_s1, sel_s2};
      {wp_s1, wp_s2}             <= {write_protect_b_i, wp_s1};
      io_s1                      <= io_i;
      io_s2                      <= io_s1;
    end
  end

  // Serial framing.
  wire       sclk_rise  = sclk_s2 & ~sclk_d;
  wire       sel_rise   = sel_s2 & ~sel_d;
  wire [2:0] step       = quad_command_mode_o ? STEP_QUAD : STEP_SINGLE;
  wire [2:0] bit_sum    = bit_cnt_reg + step;
  wire       shift_en   = sclk_rise & ~sel_s2;
  wire       byte_done  = shift_en & (bit_sum == 3'h0);
  wire [7:0] shift_next = quad_command_mode_o ? {shift_reg[3:0], io_s2} : {shift_reg[6:0], io_s2[0]};
  wire       frame_end  = sel_rise & ((byte_cnt_reg != 4'h0) | (bit_cnt_reg != 3'h0));
  wire       partial    = frame_end & (bit_cnt_reg != 3'h0);
  wire       cmd_end    = frame_end & (bit_cnt_reg == 3'h0);
  wire       one_byte   = byte_cnt_reg == LEN_OPCODE;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || sel_s2) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 4'h0;
    end else if (shift_en) begin
      bit_cnt_reg <= bit_sum;
      if (byte_done && byte_cnt_reg != 4'hF) begin
        byte_cnt_reg <= byte_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      shift_reg <= 8'h00;
      opc_reg   <= 8'h00;
      addr_reg  <= 24'h000000;
    end else if (shift_en) begin
      shift_reg <= shift_next;
      if (byte_done && byte_cnt_reg == 4'h0) begin
        opc_reg <= shift_next;
      end else if (byte_done && byte_cnt_reg < LEN_ADDR) begin
        addr_reg <= {addr_reg[15:0], shift_next};
      end
    end
  end

  // Command decode.
  wire op_kind_t dec_kind =
    (opc_reg == CMD_PAGE_PROG)    ? OP_PAGE_PROG    :
    (opc_reg == CMD_SECTOR_ERASE) ? OP_SECTOR_ERASE :
    (opc_reg == CMD_BLK32_ERASE)  ? OP_BLK32_ERASE  :
    (opc_reg == CMD_BLK64_ERASE)  ? OP_BLK64_ERASE  :
    (opc_reg == CMD_CHIP_ERASE)   ? OP_CHIP_ERASE   :
    (opc_reg == CMD_SEC_PROG)     ? OP_SEC_PROG     :
    (opc_reg == CMD_SEC_ERASE)    ? OP_SEC_ERASE    :
    (opc_reg == CMD_STATUS_WRITE) ? OP_STATUS_WRITE : OP_NONE;
  wire is_prog   = (dec_kind == OP_PAGE_PROG) | (dec_kind == OP_SEC_PROG);
  wire is_erase4 = (dec_kind == OP_SECTOR_ERASE) | (dec_kind == OP_BLK32_ERASE) |
                   (dec_kind == OP_BLK64_ERASE) | (dec_kind == OP_SEC_ERASE);
  wire len_ok    = is_prog ? (byte_cnt_reg >= LEN_ADDR_DAT) :
                   is_erase4 ? (byte_cnt_reg == LEN_ADDR) :
                   (dec_kind == OP_CHIP_ERASE) ? one_byte :
                   (byte_cnt_reg == LEN_ONE_DATA) | (byte_cnt_reg == LEN_TWO_DATA);
  wire is_array  = (dec_kind >= OP_PAGE_PROG) & (dec_kind <= OP_CHIP_ERASE);

  // The protected region and whether the target touches it.
  wire [23:0] span_mask = (dec_kind == OP_SECTOR_ERASE) ? SECTOR_MASK :
                          (dec_kind == OP_BLK32_ERASE)  ? BLK32_MASK  :
                          (dec_kind == OP_BLK64_ERASE)  ? BLK64_MASK  : 24'h000000;
  wire [23:0] op_first  = addr_reg & ~span_mask;
  wire [23:0] op_last   = op_first | span_mask;
  wire [2:0]  bp_lvl    = block_protect_bits_o[2:0];
  wire [2:0]  lvl_m1    = bp_lvl - 3'h1;
  wire [1:0]  sec_shift = (bp_lvl >= 3'h4) ? SEC_SHIFT_MAX : lvl_m1[1:0];
  wire [23:0] prot_size = block_protect_bits_o[4] ? (SECTOR_BYTES << sec_shift) : (BLKPAIR_BYTES << lvl_m1);
  wire        hit_lower = op_first < prot_size;
  wire        hit_upper = op_last >= (FLASH_BYTES - prot_size);
  wire        area_prot = (bp_lvl != 3'h0) & ((bp_lvl == BP_LVL_ALL) | (dec_kind == OP_CHIP_ERASE) |
                          (block_protect_bits_o[3] ? hit_lower : hit_upper));

  // Acceptance of modifying commands.
  wire in_standby = state_reg == ST_STANDBY;
  wire mod_try    = cmd_end & in_standby & (dec_kind != OP_NONE);
  wire mod_go     = mod_try & len_ok & write_enable_latch_o & ~(is_array & area_prot);
  wire mod_refuse = mod_try & ~mod_go;
  wire plain_cmd  = cmd_end & one_byte;
  wire arm_hit    = plain_cmd & (in_standby | (state_reg == ST_SUSPENDED)) & (opc_reg == CMD_WRITE_ENABLE);
  wire wrdi_hit   = plain_cmd & (in_standby | (state_reg == ST_SUSPENDED)) & (opc_reg == CMD_WRITE_DISABLE);
  wire can_susp   = (op_kind_o != OP_STATUS_WRITE);
  wire done       = (state_reg == ST_BUSY) & (remain_reg == 31'h1);

  // Status write; a low write-protect pin leaves both protection fields alone.
  wire        sr_write = mod_go & (dec_kind == OP_STATUS_WRITE) & wp_s2;
  wire [7:0]  sr1      = (byte_cnt_reg == LEN_ONE_DATA) ? addr_reg[7:0] : addr_reg[15:8];
  assign bp_next  = sr_write ? sr1[BP_LSB +: 5] : block_protect_bits_o;
  assign srp_next = sr_write ? {(byte_cnt_reg == LEN_TWO_DATA) ? addr_reg[SRP1_BIT] : status_protect_bits_o[1],
                                sr1[SRP0_BIT]} : status_protect_bits_o;

  // Operation time per kind; the busy window is the longest documented time.
  wire [30:0] load_count =
    (dec_kind == OP_PAGE_PROG)    ? 31'(PAGE_PROG_CYC)    :
    (dec_kind == OP_SECTOR_ERASE) ? 31'(SECTOR_ERASE_CYC) :
    (dec_kind == OP_BLK32_ERASE)  ? 31'(BLK32_ERASE_CYC)  :
    (dec_kind == OP_BLK64_ERASE)  ? 31'(BLK64_ERASE_CYC)  :
    (dec_kind == OP_CHIP_ERASE)   ? 31'(CHIP_ERASE_CYC)   :
    (dec_kind == OP_SEC_PROG)     ? 31'(SEC_PROG_CYC)     :
    (dec_kind == OP_SEC_ERASE)    ? 31'(SEC_ERASE_CYC)    :
                                    31'(STATUS_WRITE_CYC);

  // Read dummy counts, chosen as the opcode byte completes.
  wire [7:0] rd_op    = shift_next;
  wire       is_read  = (rd_op == CMD_FAST_READ) | (rd_op == CMD_DUAL_IO_READ) | (rd_op == CMD_QUAD_IO_READ) |
                        (rd_op == CMD_DTR_QUAD_READ) | (rd_op == CMD_DTR_FAST_READ) |
                        (rd_op == CMD_BURST_READ) | (rd_op == CMD_DTR_BURST);
  wire [3:0] dummy_dflt = quad_command_mode_o ? DUMMY_10 :
                          (rd_op == CMD_DUAL_IO_READ) ? DUMMY_4 :
                          ((rd_op == CMD_QUAD_IO_READ) | (rd_op == CMD_DTR_FAST_READ)) ? DUMMY_6 : DUMMY_8;
  wire [3:0] dummy_sel  = rp_valid_reg ? (DUMMY_4 + {1'b0, rp_code_reg, 1'b0}) : dummy_dflt;
  wire       read_hit   = byte_done & (byte_cnt_reg == 4'h0) & is_read &
                          (in_standby | (state_reg == ST_SUSPENDED));
  wire       rp_hit     = cmd_end & in_standby & (opc_reg == CMD_SET_READ_PAR) & (byte_cnt_reg == LEN_ONE_DATA);

  // Sequencer; deep power-down listens for nothing but release.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_STANDBY: begin
        if (mod_go) begin
          state_next = ST_BUSY;
        end else if (plain_cmd && opc_reg == CMD_DEEP_PD) begin
          state_next = ST_DEEP_PD;
        end
      end
      ST_BUSY: begin
        if (done) begin
          state_next = ST_STANDBY;
        end else if (plain_cmd && opc_reg == CMD_SUSPEND && can_susp) begin
          state_next = ST_SUSP_PEND;
        end
      end
      ST_SUSP_PEND: begin
        if (susp_cnt_reg == 10'h001) begin
          state_next = ST_SUSPENDED;
        end
      end
      ST_SUSPENDED: begin
        if (plain_cmd && opc_reg == CMD_RESUME) begin
          state_next = ST_BUSY;
        end
      end
      ST_DEEP_PD: begin
        if (plain_cmd && opc_reg == CMD_RELEASE_PD) begin
          state_next = ST_STANDBY;
        end
      end
      default: begin
        state_next = ST_STANDBY;
      end
    endcase
  end

  // Reset brings standby and an all-zero status without any command.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_reg             <= ST_STANDBY;
      write_enable_latch_o  <= 1'b0;
      block_protect_bits_o  <= BP_RESET;
      status_protect_bits_o <= SRP_RESET;
      busy_o                <= 1'b0;
      suspended_o           <= 1'b0;
      deep_power_down_o     <= 1'b0;
      quad_command_mode_o   <= 1'b0;
      cmd_reject_o          <= 1'b0;
      op_start_o            <= 1'b0;
      op_done_o             <= 1'b0;
    end else begin
      state_reg             <= state_next;
      write_enable_latch_o  <= (arm_hit | write_enable_latch_o) & ~wrdi_hit & ~done;
      block_protect_bits_o  <= bp_next;
      status_protect_bits_o <= srp_next;
      busy_o                <= (state_next == ST_BUSY) | (state_next == ST_SUSP_PEND);
      suspended_o           <= state_next == ST_SUSPENDED;
      deep_power_down_o     <= state_next == ST_DEEP_PD;
      quad_command_mode_o   <= (plain_cmd & in_standby & (opc_reg == CMD_QUAD_ON)) |
                               (quad_command_mode_o & ~(plain_cmd & in_standby & (opc_reg == CMD_QUAD_OFF)));
      cmd_reject_o          <= (partial & ~deep_power_down_o) | mod_refuse;
      op_start_o            <= mod_go;
      op_done_o             <= done;
    end
  end

  // Timers and captured operation fields; the operation clock stops while suspended.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      remain_reg   <= 31'h0;
      elapsed_reg  <= 31'h0;
      susp_cnt_reg <= 10'h000;
      op_kind_o    <= OP_NONE;
      op_addr_o    <= 24'h000000;
      read_dummy_o <= DUMMY_8;
      rp_valid_reg <= 1'b0;
      rp_code_reg  <= 2'h0;
    end else begin
      if (mod_go) begin
        remain_reg  <= load_count;
        elapsed_reg <= 31'h0;
        op_kind_o   <= dec_kind;
        op_addr_o   <= op_first;
      end else if (state_reg == ST_BUSY) begin
        remain_reg  <= remain_reg - 31'h1;
        elapsed_reg <= elapsed_reg + 31'h1;
      end
      susp_cnt_reg <= (state_next == ST_SUSP_PEND && state_reg == ST_BUSY) ? SUSPEND_LAT_CYC :
                      (state_reg == ST_SUSP_PEND) ? susp_cnt_reg - 10'h001 : susp_cnt_reg;
      if (read_hit) begin
        read_dummy_o <= dummy_sel;
      end
      if (rp_hit) begin
        rp_valid_reg <= 1'b1;
        rp_code_reg  <= addr_reg[RP_LSB +: 2];
      end
    end
  end

  a_suspend_latency: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(state_reg == ST_SUSP_PEND) |-> ##[1:751] suspended_o)
    else $error("Suspend not reached within its latency.");

  a_prog_time_bound: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (done && op_kind_o == OP_PAGE_PROG) |-> (elapsed_reg < 31'(PAGE_PROG_CYC)))
    else $error("Page program ran past its longest time.");

  a_erase_time_bound: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (done && op_kind_o == OP_SECTOR_ERASE) |-> (elapsed_reg < 31'(SECTOR_ERASE_CYC)))
    else $error("Sector erase ran past its longest time.");

  a_quad_dummy_ten: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (read_hit && quad_command_mode_o && !rp_valid_reg) |=> (read_dummy_o == DUMMY_10))
    else $error("Quad mode read did not take ten dummy cycles.");

  a_reset_status_zero: assert property (@(posedge ref_clk_i)
    $past(!rst_b_i) && rst_b_i |-> !write_enable_latch_o && block_protect_bits_o == BP_RESET &&
      status_protect_bits_o == SRP_RESET && !busy_o && !deep_power_down_o)
    else $error("Status not zero after reset.");

  a_partial_reject: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (partial && !deep_power_down_o) |=> cmd_reject_o && !op_start_o)
    else $error("A partial byte frame was not rejected.");

  a_start_needs_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    op_start_o |-> $past(write_enable_latch_o) && busy_o)
    else $error("Operation started without the write-enable latch.");

  a_protect_refuses: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (mod_try && is_array && area_prot) |=> !op_start_o && cmd_reject_o && !busy_o)
    else $error("Program or erase went into the protected region.");

  a_wp_freezes_bits: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !wp_s2 |=> $stable(block_protect_bits_o) && $stable(status_protect_bits_o))
    else $error("Protection bits changed with write-protect low.");

  a_deep_pd_ignore: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (deep_power_down_o && cmd_end && opc_reg != CMD_RELEASE_PD) |=> deep_power_down_o && !op_start_o)
    else $error("A command other than release acted in deep power-down.");

  a_done_clears_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    op_done_o |-> !write_enable_latch_o && !busy_o && $past(busy_o))
    else $error("Completion left busy or the latch set.");

endmodule

`default_nettype wire

// File: hw/flash_guard_pkg.sv
// Purpose: Shared constants for the serial flash command guard and sequencer.
// Assumes: A 25 MHz reference clock.
// Notes:   Opcode values are plain defaults and may be changed in one place.
package flash_guard_pkg;

  // Clock rate and documented times in their own units.
  localparam int  CLK_MHZ          = 25;
  localparam real SUSPEND_LAT_US   = 30.0;
  localparam real PAGE_PROG_MS     = 2.4;
  localparam real SECTOR_ERASE_MS  = 240.0;
  localparam real BLK32_ERASE_S    = 0.8;
  localparam real BLK64_ERASE_S    = 1.2;
  localparam real CHIP_ERASE_S     = 60.0;
  localparam real SEC_PROG_MS      = 2.4;
  localparam real SEC_ERASE_MS     = 240.0;
  localparam real STATUS_WRITE_MS  = 12.0;

  // Longest times, so each count is the largest whole number of cycles that fits.
  localparam int unsigned SUSPEND_LAT_CYCLES  = int'(SUSPEND_LAT_US * CLK_MHZ);
  localparam int unsigned PAGE_PROG_CYCLES    = int'(PAGE_PROG_MS * 1000.0 * CLK_MHZ);
  localparam int unsigned SECTOR_ERASE_CYCLES = int'(SECTOR_ERASE_MS * 1000.0 * CLK_MHZ);
  localparam int unsigned BLK32_ERASE_CYCLES  = int'(BLK32_ERASE_S * 1000000.0 * CLK_MHZ);
  localparam int unsigned BLK64_ERASE_CYCLES  = int'(BLK64_ERASE_S * 1000000.0 * CLK_MHZ);
  localparam int unsigned CHIP_ERASE_CYCLES   = int'(CHIP_ERASE_S * 1000000.0 * CLK_MHZ);
  localparam int unsigned SEC_PROG_CYCLES     = int'(SEC_PROG_MS * 1000.0 * CLK_MHZ);
  localparam int unsigned SEC_ERASE_CYCLES    = int'(SEC_ERASE_MS * 1000.0 * CLK_MHZ);
  localparam int unsigned STATUS_WRITE_CYCLES = int'(STATUS_WRITE_MS * 1000.0 * CLK_MHZ);
  localparam logic [9:0]  SUSPEND_LAT_CYC     = 10'(SUSPEND_LAT_CYCLES);

  // Command opcodes.
  localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_PAGE_PROG     = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] CMD_BLK32_ERASE   = 8'h52;
  localparam logic [7:0] CMD_BLK64_ERASE   = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE    = 8'hC7;
  localparam logic [7:0] CMD_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] CMD_SEC_PROG      = 8'h42;
  localparam logic [7:0] CMD_SEC_ERASE     = 8'h44;
  localparam logic [7:0] CMD_SUSPEND       = 8'h75;
  localparam logic [7:0] CMD_RESUME        = 8'h7A;
  localparam logic [7:0] CMD_DEEP_PD       = 8'hB9;
  localparam logic [7:0] CMD_RELEASE_PD    = 8'hAB;
  localparam logic [7:0] CMD_QUAD_ON       = 8'h38;
  localparam logic [7:0] CMD_QUAD_OFF      = 8'hFF;
  localparam logic [7:0] CMD_SET_READ_PAR  = 8'hC0;
  localparam logic [7:0] CMD_FAST_READ     = 8'h0B;
  localparam logic [7:0] CMD_DUAL_IO_READ  = 8'hBB;
  localparam logic [7:0] CMD_QUAD_IO_READ  = 8'hEB;
  localparam logic [7:0] CMD_DTR_QUAD_READ = 8'hED;
  localparam logic [7:0] CMD_DTR_FAST_READ = 8'h0D;
  localparam logic [7:0] CMD_BURST_READ    = 8'h0C;
  localparam logic [7:0] CMD_DTR_BURST     = 8'h0E;

  // Frame lengths in bytes.
  localparam logic [3:0] LEN_OPCODE   = 4'h1;
  localparam logic [3:0] LEN_ONE_DATA = 4'h2;
  localparam logic [3:0] LEN_TWO_DATA = 4'h3;
  localparam logic [3:0] LEN_ADDR     = 4'h4;
  localparam logic [3:0] LEN_ADDR_DAT = 4'h5;

  // Serial framing.
  localparam logic [2:0] STEP_SINGLE = 3'h1;
  localparam logic [2:0] STEP_QUAD   = 3'h4;

  // Status byte layout and reset value.
  localparam int         BP_LSB      = 2;
  localparam int         SRP0_BIT    = 7;
  localparam int         SRP1_BIT    = 0;
  localparam int         RP_LSB      = 4;
  localparam logic [4:0] BP_RESET    = 5'h00;
  localparam logic [1:0] SRP_RESET   = 2'h0;

  // Array geometry and protection units.
  localparam logic [23:0] FLASH_BYTES  = 24'h800000;
  localparam logic [23:0] SECTOR_MASK  = 24'h000FFF;
  localparam logic [23:0] BLK32_MASK   = 24'h007FFF;
  localparam logic [23:0] BLK64_MASK   = 24'h00FFFF;
  localparam logic [23:0] SECTOR_BYTES = 24'h001000;
  localparam logic [23:0] BLKPAIR_BYTES = 24'h020000;
  localparam logic [2:0]  BP_LVL_ALL   = 3'h7;
  localparam logic [1:0]  SEC_SHIFT_MAX = 2'h3;

  // Dummy cycle counts.
  localparam logic [3:0] DUMMY_4  = 4'h4;
  localparam logic [3:0] DUMMY_6  = 4'h6;
  localparam logic [3:0] DUMMY_8  = 4'h8;
  localparam logic [3:0] DUMMY_10 = 4'hA;

  typedef enum logic [2:0] {
    ST_STANDBY   = 3'h0,
    ST_BUSY      = 3'h1,
    ST_SUSP_PEND = 3'h2,
    ST_SUSPENDED = 3'h3,
    ST_DEEP_PD   = 3'h4
  } seq_state_t;

  typedef enum logic [3:0] {
    OP_NONE         = 4'h0,
    OP_PAGE_PROG    = 4'h1,
    OP_SECTOR_ERASE = 4'h2,
    OP_BLK32_ERASE  = 4'h3,
    OP_BLK64_ERASE  = 4'h4,
    OP_CHIP_ERASE   = 4'h5,
    OP_SEC_PROG     = 4'h6,
    OP_SEC_ERASE    = 4'h7,
    OP_STATUS_WRITE = 4'h8
  } op_kind_t;

endpackage
